// [sct_defines.svh]
`ifndef SCT_DEFINES_SVH
`define SCT_DEFINES_SVH
// ----------------------------------------
// Sizes
// ----------------------------------------
`define SCT_NUM_EV 8
`define SCT_NUM_REG 8
`define SCT_NUM_OUT 6
`define SCT_NUM_IN 4
`define SCT_NUM_SRC 8
`define SCT_NUM_IO 10
`define SCT_HALF_W 16
`define SCT_CNT_W 32
`define SCT_STATE_W 3
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define SCT_STATE_RST 3'h0
`define SCT_HALF_ZERO 16'h0000
`define SCT_HALF_MAX 16'hffff
`define SCT_CNT_ZERO 32'h0
`define SCT_IO_LAST 4'h9
// ----------------------------------------
// Timing
// ----------------------------------------
`define SCT_CLK_MHZ 250
`define SCT_IN_MAX_MHZ 25
// Least clock cycles per half period of the fastest legal input
`define SCT_IN_MIN_CYC ((`SCT_CLK_MHZ + 2 * `SCT_IN_MAX_MHZ - 1) / (2 * `SCT_IN_MAX_MHZ))
`endif

// [sct_pkg.sv]
package sct_pkg;
    // ----------------------------------------
    // Event condition encodings
    // ----------------------------------------
    typedef enum logic [1:0] {sct_io_low, sct_io_rise, sct_io_fall, sct_io_high} sct_io_cond_t;
    typedef enum logic [1:0] {sct_cmb_or, sct_cmb_match, sct_cmb_io, sct_cmb_and} sct_comb_t;
    typedef enum logic [1:0] {sct_dir_any, sct_dir_up, sct_dir_down} sct_dirq_t;
endpackage : sct_pkg

// [sct_ctr_if.sv]
`timescale 1ns/1ps
`include "sct_defines.svh"
// Link between the control logic and one counter half
interface sct_ctr_if;
    logic tick;
    logic down;
    logic clear;
    logic carry;
    logic [`SCT_HALF_W-1:0] count;
    modport counter (input tick, input down, input clear, output count, output carry);
    modport ctl (output tick, output down, output clear, input count, input carry);
endinterface : sct_ctr_if

// [sct_sync.sv]
`timescale 1ns/1ps
`include "sct_defines.svh"
module sct_sync #(
    parameter int WIDTH = `SCT_NUM_SRC
) (
    input logic clock,
    input logic rst_n,
    input logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // Two-stage synchroniser; only the second stage is read
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

    property p_sync_lag;
        @(posedge clock) disable iff (!rst_n)
        ($past(rst_n, 1) && $past(rst_n, 2)) |-> sync_out == $past(async_in, 2);
    endproperty
    a_sync_lag: assert property (p_sync_lag)
        else $error("synchroniser lag is not two cycles");
endmodule : sct_sync

// [sct_counter.sv]
`timescale 1ns/1ps
`include "sct_defines.svh"
module sct_counter (
    input logic clock,
    input logic rst_n,
    sct_ctr_if.counter bus
);
    logic at_end;

    // Wrap point depends on direction; carry feeds the upper half when joined
    assign at_end = bus.down ? (bus.count == `SCT_HALF_ZERO) : (bus.count == `SCT_HALF_MAX);
    assign bus.carry = bus.tick & at_end;

    // Clear beats counting so a limit lands on zero in up-only mode
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bus.count <= `SCT_HALF_ZERO;
        end else if (bus.clear) begin
            bus.count <= `SCT_HALF_ZERO;
        end else if (bus.tick) begin
            bus.count <= bus.down ? bus.count - 16'h0001 : bus.count + 16'h0001;
        end
    end

    property p_count_step;
        @(posedge clock) disable iff (!rst_n)
        (bus.tick && !bus.clear) |=>
            bus.count == ($past(bus.down) ? $past(bus.count) - 16'h0001
                                          : $past(bus.count) + 16'h0001);
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not step by one");
endmodule : sct_counter

// [sct_timer.sv]
// Function
// - Counter runs as one 32-bit counter or two independent 16-bit halves.
// - Eight events drive a state variable of up to eight states.
// - Eight registers, each usable as a match or a capture register.
// - Four inputs, each picked from pins or internal sources, up to 25 MHz.
// - Every selector offers four pins plus four internal on-chip signals.
// - Six outputs routed toward device pins.
// - Counters tick on the system clock or a selected input edge.
// - Each counter counts up only, or up then down.
// - Matches can interrupt, stop, limit, halt, reverse or toggle outputs.
// - Counter value copied into capture register on a match or I/O toggle.
// - Up to six PWM outputs, own duty, shared cycle length.
// - Event condition is match, I/O edge or level, or a mix.
// - Events can limit, halt, start, stop or reverse a counter.
// - Events can change state, toggle outputs, raise interrupt and DMA requests.
// - Match register zero can act as automatic counter limit.
// - Events can be qualified by the counting direction.
// - A match can stay pending until the event fires.
// - Each event acts only in its assigned states.
// - State persists across counter wrap and limit.
// - One output is selectable as converter trigger.
`timescale 1ns/1ps
`include "sct_defines.svh"
module sct_timer (
    input logic clock,
    input logic rst_n,
    input logic [`SCT_NUM_IN-1:0] pin_in,
    input logic adc_thcmp_irq,
    input logic comparator_out,
    input logic cpu_event_out,
    input logic core_a,
    input logic [`SCT_NUM_IN-1:0][2:0] input_source_selector,
    input logic unify,
    input logic [1:0] bidir,
    input logic [1:0] auto_limit,
    input logic clk_from_input,
    input logic [1:0] clk_input_sel,
    input logic [1:0] sw_start,
    input logic [1:0] sw_stop,
    input logic [1:0] sw_unhalt,
    input logic [`SCT_NUM_REG-1:0] reg_is_capture,
    input logic [`SCT_NUM_REG-1:0][`SCT_CNT_W-1:0] match_val,
    input logic [`SCT_NUM_REG-1:0][`SCT_NUM_EV-1:0] cap_event,
    input logic [`SCT_NUM_EV-1:0][`SCT_NUM_EV-1:0] ev_state_mask,
    input logic [`SCT_NUM_EV-1:0][2:0] ev_match_sel,
    input logic [`SCT_NUM_EV-1:0][3:0] ev_io_sel,
    input sct_pkg::sct_io_cond_t [`SCT_NUM_EV-1:0] ev_io_cond,
    input sct_pkg::sct_comb_t [`SCT_NUM_EV-1:0] ev_comb,
    input sct_pkg::sct_dirq_t [`SCT_NUM_EV-1:0] ev_dir_qual,
    input logic [`SCT_NUM_EV-1:0] ev_half,
    input logic [`SCT_NUM_EV-1:0] ev_hold,
    input logic [`SCT_NUM_EV-1:0] ev_state_load,
    input logic [`SCT_NUM_EV-1:0][`SCT_STATE_W-1:0] ev_state_next,
    input logic [`SCT_NUM_EV-1:0] ev_limit,
    input logic [`SCT_NUM_EV-1:0] ev_halt,
    input logic [`SCT_NUM_EV-1:0] ev_start,
    input logic [`SCT_NUM_EV-1:0] ev_stop,
    input logic [`SCT_NUM_EV-1:0] ev_reverse,
    input logic [`SCT_NUM_OUT-1:0][`SCT_NUM_EV-1:0] out_set,
    input logic [`SCT_NUM_OUT-1:0][`SCT_NUM_EV-1:0] out_clr,
    input logic [`SCT_NUM_EV-1:0] irq_enable,
    input logic [1:0][`SCT_NUM_EV-1:0] dma_enable,
    input logic [2:0] adc_trig_sel,
    output logic [`SCT_NUM_OUT-1:0] sct_out,
    output logic adc_trigger,
    output logic [`SCT_CNT_W-1:0] count_value,
    output logic [`SCT_NUM_REG-1:0][`SCT_CNT_W-1:0] cap_value,
    output logic [`SCT_STATE_W-1:0] state_now,
    output logic [1:0] running,
    output logic [1:0] halted,
    output logic [1:0] counting_down,
    output logic [`SCT_NUM_EV-1:0] event_pulse,
    output logic irq,
    output logic [1:0] dma_req
);
    logic [`SCT_NUM_SRC-1:0] src_raw;
    logic [`SCT_NUM_SRC-1:0] src;
    logic [`SCT_NUM_IN-1:0] sel_in;
    logic [`SCT_NUM_IN-1:0] in_prev;
    logic [`SCT_NUM_OUT-1:0] out_q;
    logic [`SCT_NUM_OUT-1:0] out_prev;
    logic [`SCT_NUM_OUT-1:0] next_out;
    logic [`SCT_NUM_OUT-1:0] oset;
    logic [`SCT_NUM_OUT-1:0] oclr;
    logic [`SCT_NUM_IO-1:0] io_cur;
    logic [`SCT_NUM_IO-1:0] io_prv;
    logic tick_base;
    logic [1:0][`SCT_HALF_W-1:0] cnt;
    logic [1:0] carry;
    logic [`SCT_CNT_W-1:0] count32;
    logic [1:0] run;
    logic [1:0] halt_q;
    logic [1:0] down;
    logic [1:0] en;
    logic [1:0] zero;
    logic [1:0] hold0;
    logic [1:0] hit0;
    logic [1:0] lim;
    logic [1:0] lim_act;
    logic [1:0] tick;
    logic [1:0] clear;
    logic [1:0] rev;
    logic [1:0] start;
    logic [1:0] stop;
    logic [1:0] halt_set;
    logic [1:0][`SCT_NUM_EV-1:0] act;
    logic [`SCT_NUM_EV-1:0] eff;
    logic [`SCT_NUM_EV-1:0] raw_hit;
    logic [`SCT_NUM_EV-1:0] io_ok;
    logic [`SCT_NUM_EV-1:0] dir_ok;
    logic [`SCT_NUM_EV-1:0] fired;
    logic [`SCT_NUM_EV-1:0] pend;
    logic [`SCT_NUM_REG-1:0] cap_go;
    logic [`SCT_STATE_W-1:0] state;
    logic [`SCT_STATE_W-1:0] next_state_val;
    logic ld_any;
    logic io_c;
    logic io_p;

    // ----------------------------------------
    // Input selection
    // ----------------------------------------
    // Internal sources are synchronised too; they may come from other clocks
    assign src_raw = {core_a, cpu_event_out, comparator_out, adc_thcmp_irq, pin_in};
    sct_sync #(.WIDTH(`SCT_NUM_SRC)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in(src_raw),
        .sync_out(src)
    );

    // One selector per input, identical source set
    always_comb begin
        for (int i = 0; i < `SCT_NUM_IN; i++) begin
            sel_in[i] = src[input_source_selector[i]];
        end
    end

    // Inputs below outputs so one 4-bit code reaches all ten signals
    assign io_cur = {out_q, sel_in};
    assign io_prv = {out_prev, in_prev};
    // Input clocking uses rising edges; two edges need at least two cycles apart
    assign tick_base = clk_from_input ? (sel_in[clk_input_sel] & ~in_prev[clk_input_sel])
                                      : 1'b1;
    assign count32 = {cnt[1], cnt[0]};

    // ----------------------------------------
    // Match compare
    // ----------------------------------------
    // A register set for capture never matches
    function automatic logic reg_hit(input logic [2:0] r, input logic c);
        logic [`SCT_HALF_W-1:0] half_val;
        half_val = c ? match_val[r][31:16] : match_val[r][15:0];
        if (reg_is_capture[r]) begin
            reg_hit = 1'b0;
        end else if (unify) begin
            reg_hit = (count32 == match_val[r]);
        end else begin
            reg_hit = (cnt[c] == half_val);
        end
    endfunction : reg_hit

    // ----------------------------------------
    // Event evaluation
    // ----------------------------------------
    always_comb begin
        act = '0;
        io_c = 1'b0;
        io_p = 1'b0;
        for (int e = 0; e < `SCT_NUM_EV; e++) begin
            eff[e] = ev_half[e] & ~unify;
            raw_hit[e] = reg_hit(ev_match_sel[e], eff[e]);
            io_c = 1'b0;
            io_p = 1'b0;
            if (ev_io_sel[e] <= `SCT_IO_LAST) begin
                io_c = io_cur[ev_io_sel[e]];
                io_p = io_prv[ev_io_sel[e]];
            end
            case (ev_io_cond[e])
                sct_pkg::sct_io_low: io_ok[e] = ~io_c;
                sct_pkg::sct_io_rise: io_ok[e] = io_c & ~io_p;
                sct_pkg::sct_io_fall: io_ok[e] = ~io_c & io_p;
                default: io_ok[e] = io_c;
            endcase
            case (ev_dir_qual[e])
                sct_pkg::sct_dir_up: dir_ok[e] = ~down[eff[e]];
                sct_pkg::sct_dir_down: dir_ok[e] = down[eff[e]];
                default: dir_ok[e] = 1'b1;
            endcase
            fired[e] = ev_state_mask[e][state] & dir_ok[e];
            case (ev_comb[e])
                sct_pkg::sct_cmb_or: fired[e] = fired[e] & ((raw_hit[e] | pend[e]) | io_ok[e]);
                sct_pkg::sct_cmb_match: fired[e] = fired[e] & (raw_hit[e] | pend[e]);
                sct_pkg::sct_cmb_io: fired[e] = fired[e] & io_ok[e];
                default: fired[e] = fired[e] & (raw_hit[e] | pend[e]) & io_ok[e];
            endcase
            act[eff[e]][e] = fired[e];
        end
    end

    // Held match; a new hit beats the clear by the firing event
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pend <= '0;
        end else begin
            pend <= (pend & ~fired) | (raw_hit & ev_hold);
        end
    end

    // ----------------------------------------
    // Counter control, one set per half
    // ----------------------------------------
    // In joined mode only the lower set steers; the upper half follows its carry
    always_comb begin
        for (int h = 0; h < 2; h++) begin
            hit0[h] = reg_hit(3'h0, h[0]);
            lim[h] = (auto_limit[h] & hit0[h]) | (|(act[h] & ev_limit));
            rev[h] = |(act[h] & ev_reverse);
            start[h] = sw_start[h] | (|(act[h] & ev_start));
            stop[h] = |(act[h] & ev_stop);
            halt_set[h] = |(act[h] & ev_halt);
            zero[h] = unify ? (count32 == `SCT_CNT_ZERO) : (cnt[h] == `SCT_HALF_ZERO);
            hold0[h] = down[h] & zero[h];
        end
        en[0] = run[0] & ~halt_q[0] & tick_base;
        en[1] = ~unify & run[1] & ~halt_q[1] & tick_base;
        for (int h = 0; h < 2; h++) begin
            // Turning at the limit holds one cycle; a down-count passes it freely
            lim_act[h] = en[h] & lim[h] & ~(bidir[h] & down[h]);
            tick[h] = en[h] & ~hold0[h] & ~lim_act[h];
            clear[h] = lim_act[h] & ~bidir[h];
        end
        if (unify) begin
            tick[1] = tick[0] & carry[0];
            clear[1] = clear[0];
        end
    end

    // Direction: reverse event wins, then turn at zero, then turn at limit
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            down <= 2'h0;
        end else begin
            for (int h = 0; h < 2; h++) begin
                if (!bidir[h]) begin
                    down[h] <= 1'b0;
                end else if (rev[h]) begin
                    down[h] <= ~down[h];
                end else if (en[h] && hold0[h]) begin
                    down[h] <= 1'b0;
                end else if (lim_act[h]) begin
                    down[h] <= 1'b1;
                end
            end
        end
    end

    // Run and halt; a halt stays until software lifts it, set beats clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            run <= 2'h0;
            halt_q <= 2'h0;
        end else begin
            for (int h = 0; h < 2; h++) begin
                if (start[h]) begin
                    run[h] <= 1'b1;
                end else if (stop[h] || sw_stop[h]) begin
                    run[h] <= 1'b0;
                end
                halt_q[h] <= halt_set[h] | (halt_q[h] & ~sw_unhalt[h]);
            end
        end
    end

    // Two 16-bit halves chained by carry when joined
    for (genvar h = 0; h < 2; h++) begin : g_half
        sct_ctr_if u_if();
        sct_counter u_cnt (
            .clock(clock),
            .rst_n(rst_n),
            .bus(u_if)
        );
        assign u_if.tick = tick[h];
        assign u_if.clear = clear[h];
        assign u_if.down = unify ? down[0] : down[h];
        assign cnt[h] = u_if.count;
        assign carry[h] = u_if.carry;
    end

    // ----------------------------------------
    // State, outputs, capture
    // ----------------------------------------
    // Higher-numbered event wins when several load the state together
    always_comb begin
        ld_any = 1'b0;
        next_state_val = state;
        for (int e = 0; e < `SCT_NUM_EV; e++) begin
            if (fired[e] && ev_state_load[e]) begin
                ld_any = 1'b1;
                next_state_val = ev_state_next[e];
            end
        end
        for (int o = 0; o < `SCT_NUM_OUT; o++) begin
            oset[o] = |(fired & out_set[o]);
            oclr[o] = |(fired & out_clr[o]);
            if (oset[o] && oclr[o]) begin
                next_out[o] = ~out_q[o];
            end else if (oset[o]) begin
                next_out[o] = 1'b1;
            end else if (oclr[o]) begin
                next_out[o] = 1'b0;
            end else begin
                next_out[o] = out_q[o];
            end
        end
        for (int i = 0; i < `SCT_NUM_REG; i++) begin
            cap_go[i] = reg_is_capture[i] & (|(fired & cap_event[i]));
        end
    end

    // State is untouched by wrap or limit
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= `SCT_STATE_RST;
        end else if (ld_any) begin
            state <= next_state_val;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            out_q <= '0;
            out_prev <= '0;
            in_prev <= '0;
            adc_trigger <= 1'b0;
        end else begin
            out_q <= next_out;
            out_prev <= out_q;
            in_prev <= sel_in;
            adc_trigger <= (adc_trig_sel < 3'h6) ? out_q[adc_trig_sel] : 1'b0;
        end
    end

    // Capture takes both halves as one word in either mode
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cap_value <= '0;
        end else begin
            for (int i = 0; i < `SCT_NUM_REG; i++) begin
                if (cap_go[i]) begin
                    cap_value[i] <= count32;
                end
            end
        end
    end

    // Registered event requests
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            event_pulse <= '0;
            irq <= 1'b0;
            dma_req <= 2'h0;
        end else begin
            event_pulse <= fired;
            irq <= |(fired & irq_enable);
            dma_req[0] <= |(fired & dma_enable[0]);
            dma_req[1] <= |(fired & dma_enable[1]);
        end
    end

    assign sct_out = out_q;
    assign count_value = count32;
    assign state_now = state;
    assign running = run;
    assign halted = halt_q;
    assign counting_down = down;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_state_hold;
        !ld_any |=> $stable(state_now);
    endproperty
    a_state_hold: assert property (p_state_hold)
        else $error("state moved without an event");

    property p_state_load;
        ld_any |=> state_now == $past(next_state_val);
    endproperty
    a_state_load: assert property (p_state_load)
        else $error("state not loaded by event");

    property p_state_mask;
        fired[0] |-> ev_state_mask[0][state_now];
    endproperty
    a_state_mask: assert property (p_state_mask)
        else $error("event fired outside its states");

    property p_dir_qual;
        (fired[3] && ev_dir_qual[3] == sct_pkg::sct_dir_down) |-> counting_down[eff[3]];
    endproperty
    a_dir_qual: assert property (p_dir_qual)
        else $error("down-only event fired while counting up");

    property p_halt;
        (halted == 2'h3) |=> $stable(count_value);
    endproperty
    a_halt: assert property (p_halt)
        else $error("halted counter moved");

    property p_halt_hi;
        (halted[1] && !unify) |=> $stable(cnt[1]);
    endproperty
    a_halt_hi: assert property (p_halt_hi)
        else $error("halted upper half moved");

    property p_auto_limit;
        (en[0] && auto_limit[0] && !bidir[0] && !unify && !reg_is_capture[0]
            && cnt[0] == match_val[0][15:0]) |=> cnt[0] == `SCT_HALF_ZERO;
    endproperty
    a_auto_limit: assert property (p_auto_limit)
        else $error("match zero did not limit the count");

    property p_capture;
        cap_go[0] |=> cap_value[0] == $past(count_value);
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture missed the counter value");

    property p_out_toggle;
        (oset[0] && oclr[0]) |=> sct_out[0] != $past(sct_out[0]);
    endproperty
    a_out_toggle: assert property (p_out_toggle)
        else $error("output did not toggle");

    property p_pend;
        (pend[0] && !fired[0]) |=> pend[0];
    endproperty
    a_pend: assert property (p_pend)
        else $error("held match dropped before event");

    property p_adc;
        (adc_trig_sel < 3'h6) |=> adc_trigger == $past(sct_out[adc_trig_sel]);
    endproperty
    a_adc: assert property (p_adc)
        else $error("converter trigger does not follow output");

    property p_unify;
        (unify && tick[0] && carry[0]) |=> cnt[1] != $past(cnt[1]);
    endproperty
    a_unify: assert property (p_unify)
        else $error("upper half missed the carry");
endmodule : sct_timer

// [sct_src_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Far side: routed pins and on-chip sources
// ----------------------------------------
module sct_src_model (
    input wire logic clock,
    output logic [3:0] pin_in,
    output logic adc_thcmp_irq,
    output logic comparator_out,
    output logic cpu_event_out,
    output logic core_a
);
    logic [7:0] src = 8'h00;

    // Sources rest low between bursts, so a selector change never makes an edge
    assign {core_a, cpu_event_out, comparator_out, adc_thcmp_irq, pin_in} = src;

    // Five-cycle half periods keep each source at the fastest legal input rate
    task automatic make_edges(input int code, input int n);
        for (int i = 0; i < n; i++) begin
            repeat (5) @(posedge clock);
            #1 src[code] = 1'b1;
            repeat (5) @(posedge clock);
            #1 src[code] = 1'b0;
        end
    endtask : make_edges
endmodule : sct_src_model

// [tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t ns: output differs from model", $time); end end
module tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] pin_in;
    logic adc_thcmp_irq, comparator_out, cpu_event_out, core_a, unify, clk_from_input;
    logic [3:0][2:0] input_source_selector;
    logic [1:0] bidir, auto_limit, clk_input_sel, sw_start, sw_stop, sw_unhalt;
    logic [7:0] reg_is_capture, ev_half, ev_hold, ev_state_load, ev_limit, ev_halt;
    logic [7:0] ev_start, ev_stop, ev_reverse, irq_enable, event_pulse;
    logic [7:0][31:0] match_val, cap_value;
    logic [7:0][7:0] cap_event, ev_state_mask;
    logic [7:0][2:0] ev_match_sel, ev_state_next;
    logic [7:0][3:0] ev_io_sel;
    sct_pkg::sct_io_cond_t [7:0] ev_io_cond;
    sct_pkg::sct_comb_t [7:0] ev_comb;
    sct_pkg::sct_dirq_t [7:0] ev_dir_qual;
    logic [5:0][7:0] out_set, out_clr;
    logic [1:0][7:0] dma_enable;
    logic [2:0] adc_trig_sel, state_now;
    logic [5:0] sct_out;
    logic adc_trigger, irq;
    logic [31:0] count_value;
    logic [1:0] running, halted, counting_down, dma_req;
    int errors = 0, n_compared = 0, cycles = 0, n_ev = 0, n_dma = 0;
    int m_cnt = 0, m_hi = 0, m_state = 0, m_cap = 0;
    bit m_run = 0, m_dn = 0, m_halt = 0, m_out = 0, m_adc = 0;
    logic [1:0] m_pulse = 2'b00;
    logic [31:0] seed = 32'hbe806bf4;

    sct_timer i_sct_timer (.*);
    sct_src_model i_sct_src_model (.*);

    // Clock at 250 MHz
    initial forever #2 clock = ~clock;

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift

    task tally_and_finish();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------
    // Model: half 0 counts 0..2, event 0 at 2, event 1 at 1 in state 1 only
    // Half 1 counts up-down 0..3; event 3 fires at 2 on the way down and halts it at 1
    // ----------------------------------------
    always @(posedge clock) begin
        if (!rst_n) begin
            {m_cnt, m_hi, m_state, m_cap, m_run, m_dn, m_halt, m_out, m_adc, m_pulse} <= '0;
        end else begin
            if (m_run) m_cnt <= (m_cnt == 2) ? 0 : m_cnt + 1;
            // Both turning points hold the count for one cycle
            if (m_run && !m_halt) begin
                if (m_hi == (m_dn ? 0 : 3)) m_dn <= !m_dn;
                else m_hi <= m_dn ? m_hi - 1 : m_hi + 1;
            end
            if (|ev_state_mask[3] && m_dn && m_hi == 2) m_halt <= 1'b1;
            if (sw_start[0]) m_run <= 1'b1;
            m_pulse <= {m_cnt == 1 && m_state == 1, m_cnt == 2};
            if (m_cnt == 2) m_state <= 1;
            if (m_cnt == 2) m_out <= 1'b1;
            else if (m_cnt == 1 && m_state == 1) m_out <= 1'b0;
            if (m_cnt == 1 && m_state == 1) m_cap <= m_hi * 65536 + m_cnt;
            m_adc <= m_out;
        end
    end

    // Compare on the falling edge, where every registered output has settled
    always @(negedge clock) begin
        cycles++;
        `CHK(count_value, ({16'(m_hi), 16'(m_cnt)}))
        `CHK(running, ({m_run, m_run}))
        `CHK(halted, ({m_halt, 1'b0}))
        `CHK(counting_down, ({m_dn, 1'b0}))
        `CHK(({dma_req[1], sct_out[5:1]}), 6'h00)
        `CHK(cap_value[6:0], '0)
        `CHK(state_now, 3'(m_state))
        `CHK(event_pulse[1:0], m_pulse)
        `CHK(sct_out[0], m_out)
        `CHK(irq, m_pulse[0])
        `CHK(cap_value[7], 32'(m_cap))
        `CHK(adc_trigger, m_adc)
        n_ev += int'(event_pulse[2]);
        n_dma += int'(dma_req[0]);
        // Ceiling well above the few hundred cycles the run needs
        if (cycles == 3000) begin
            errors++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        {input_source_selector, unify, clk_from_input, bidir, clk_input_sel, sw_start,
            sw_stop, sw_unhalt, ev_half, ev_hold, ev_state_load, ev_limit, ev_halt,
            ev_start, ev_stop, ev_reverse, cap_event, ev_state_mask, ev_match_sel,
            ev_state_next, ev_io_sel, out_set, out_clr, dma_enable, adc_trig_sel} = '0;
        for (int i = 0; i < 8; i++) begin
            ev_io_cond[i] = sct_pkg::sct_io_rise;
            ev_comb[i] = sct_pkg::sct_cmb_match;
            ev_dir_qual[i] = sct_pkg::sct_dir_any;
            match_val[i] = xorshift();
        end
        match_val[0] = 32'h00030002;
        match_val[1] = 32'h00000001;
        match_val[2] = 32'h00020000;
        auto_limit = 2'b11;
        bidir = 2'b10;
        ev_half = 8'h08;
        ev_halt = 8'h08;
        ev_match_sel[3] = 3'h2;
        ev_dir_qual[3] = sct_pkg::sct_dir_down;
        reg_is_capture = 8'h80;
        cap_event[7] = 8'h02;
        ev_state_mask[0] = 8'hff;
        ev_state_mask[1] = 8'h02;
        ev_state_mask[2] = 8'hff;
        ev_match_sel[1] = 3'h1;
        ev_state_load = 8'h01;
        ev_state_next[0] = 3'h1;
        out_set[0] = 8'h01;
        out_clr[0] = 8'h02;
        irq_enable = 8'h01;
        ev_comb[2] = sct_pkg::sct_cmb_io;
        dma_enable[0] = 8'h04;
        repeat (5) @(posedge clock);
        #1 rst_n = 1'b1;
        @(posedge clock);
        #1 sw_start = 2'b11;
        repeat (40) @(posedge clock);
        // Every selector code feeds timer input 0 a random burst of rising edges
        for (int code = 0; code < 8; code++) begin
            int n;
            n = int'(xorshift() % 4) + 1;
            #1 input_source_selector[0] = 3'(code);
            repeat (4) @(posedge clock);
            #1 n_ev = 0;
            n_dma = 0;
            i_sct_src_model.make_edges(code, n);
            repeat (10) @(posedge clock);
            `CHK(n_ev, n)
            `CHK(n_dma, n)
        end
        // Arm the down-only halt event on half 1; one up-down period is eight cycles
        #1 ev_state_mask[3] = 8'hff;
        repeat (30) @(posedge clock);
        `CHK(halted[1], 1'b1)
        tally_and_finish();
    end
endmodule : tb
